// file: verilog/plcr_defs.vh
// Purpose: Constants for the indicator override and transceiver control registers.
// Assumes: 50 MHz clock, AXI4-Lite register access, 16-bit registers in 32-bit words.
// Notes:   Byte address of a register is four times its index.
//
// Summary of operation
// - Override enable drives stored force value onto link indicator pin.
// - Override bit 1 is writable force level, reset zero.
// - Override register reads stored bits, never the actual pin level.
// - Reserved bits ignore writes and read zero in both registers.
// - Bit 15 enables automatic crossover, strap default, software writable.
// - Bit 14 forces crossed pair assignment.
// - Read-only bit 13 reports resolved pause receive.
// - Read-only bit 12 reports resolved pause transmit.
// - Pause bits assert only when agreed technology is full duplex.
// - Writing one to bit 11 injects one self-test error, then clears.
// - Bit 8 runs self test, bit 10 picks sequence, bit 9 latches pass.
// - Bit 7 bypasses indicator pulse stretching.
// - Bit 5 selects indicator mode 1 or 2, strap default.
// - Bits 4:0 hold management address, strap loaded, software writable.
`ifndef PLCR_DEFS_VH
`define PLCR_DEFS_VH

`define PLCR_IDX_OVERRIDE   6'h18
`define PLCR_IDX_CONTROL    6'h19
`define PLCR_IDX_IRQ_STATUS 6'h1c
`define PLCR_IDX_IRQ_CLEAR  6'h1d
`define PLCR_IDX_IRQ_ENABLE 6'h1e

`define PLCR_OVR_EN_BIT     4
`define PLCR_OVR_VAL_BIT    1
`define PLCR_OVR_MASK       16'h0012

`define PLCR_CTL_XOVER_AUTO 15
`define PLCR_CTL_XOVER_FORCE 14
`define PLCR_CTL_PAUSE_RX   13
`define PLCR_CTL_PAUSE_TX   12
`define PLCR_CTL_INJECT     11
`define PLCR_CTL_LONG_SEQ   10
`define PLCR_CTL_PASS       9
`define PLCR_CTL_RUN        8
`define PLCR_CTL_BYPASS     7
`define PLCR_CTL_MODE       5

`define PLCR_IRQ_FAIL       0
`define PLCR_IRQ_PAUSE      1
`define PLCR_IRQ_LINK       2
`define PLCR_IRQ_W          3

`define PLCR_RESP_OKAY      2'b00
`define PLCR_RESP_SLVERR    2'b10

`define PLCR_CLK_MHZ        50
`define PLCR_STRETCH_MS     50
`define PLCR_STRETCH_CYCLES (`PLCR_STRETCH_MS * `PLCR_CLK_MHZ * 1000)

`define PLCR_SEQ_LEN        15

`endif

// file: verilog/plcr_axil_slave.v
// Purpose: AXI4-Lite slave turning bus transfers into register strobes.
// Assumes: One write and one read outstanding at most.
// Notes:   Write strobe fires one edge after both address and data are held.
`timescale 1ns/1ps
`include "plcr_defs.vh"
module plcr_axil_slave (
  input  wire        clk_in,
  input  wire        reset_n_in,
  input  wire        ce_in,
  input  wire [7:0]  awaddr_in,
  input  wire        awvalid_in,
  output wire        awready_out,
  input  wire [31:0] wdata_in,
  input  wire [3:0]  wstrb_in,
  input  wire        wvalid_in,
  output wire        wready_out,
  output reg  [1:0]  bresp_out,
  output reg         bvalid_out,
  input  wire        bready_in,
  input  wire [7:0]  araddr_in,
  input  wire        arvalid_in,
  output wire        arready_out,
  output reg  [31:0] rdata_out,
  output reg  [1:0]  rresp_out,
  output reg         rvalid_out,
  input  wire        rready_in,
  output wire        wr_en_out,
  output wire [7:0]  wr_addr_out,
  output wire [31:0] wr_data_out,
  output wire [3:0]  wr_strb_out,
  input  wire        wr_hit_in,
  output wire [7:0]  rd_addr_out,
  input  wire [15:0] rd_data_in,
  input  wire        rd_hit_in
);
  reg        aw_full_reg;
  reg        w_full_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  assign awready_out = ce_in & ~aw_full_reg & ~bvalid_out;
  assign wready_out  = ce_in & ~w_full_reg & ~bvalid_out;
  assign arready_out = ce_in & ~rvalid_out;
  assign wr_en_out   = ce_in & aw_full_reg & w_full_reg & ~bvalid_out;
  assign wr_addr_out = aw_addr_reg;
  assign wr_data_out = w_data_reg;
  assign wr_strb_out = w_strb_reg;
  assign rd_addr_out = araddr_in;

  // Address and data are caught in either order, then the write fires.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_out  <= 1'b0;
      bresp_out   <= 2'b00;
    end else if (ce_in) begin
      if (awvalid_in && awready_out) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata_in;
        w_strb_reg <= wstrb_in;
      end
      if (wr_en_out) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_out  <= 1'b1;
        bresp_out   <= wr_hit_in ? `PLCR_RESP_OKAY : `PLCR_RESP_SLVERR;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // Read data are taken at the address edge and held until accepted.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= 32'h0000_0000;
      rresp_out  <= 2'b00;
    end else if (ce_in) begin
      if (arvalid_in && arready_out) begin
        rvalid_out <= 1'b1;
        rdata_out  <= {16'h0000, rd_data_in};
        rresp_out  <= rd_hit_in ? `PLCR_RESP_OKAY : `PLCR_RESP_SLVERR;
      end else if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
      end
    end
  end
endmodule

// file: verilog/plcr_selftest.v
// Purpose: Pseudo-random self-test generator and self-synchronising checker.
// Assumes: Received stream is the transmitted stream looped back.
// Notes:   Checking starts once the checker history has filled.
`timescale 1ns/1ps
`include "plcr_defs.vh"
module plcr_selftest #(
  parameter W = `PLCR_SEQ_LEN
) (
  input  wire clk_in,
  input  wire reset_n_in,
  input  wire ce_in,
  input  wire run_in,
  input  wire long_sel_in,
  input  wire inject_in,
  input  wire rx_bit_in,
  output reg  tx_bit_out,
  output reg  pass_out,
  output reg  fail_out
);
  reg  [W-1:0] gen_reg;
  reg  [W-1:0] chk_reg;
  reg  [3:0]   fill_reg;
  reg          active_reg;
  wire         gen_fb;
  wire         chk_fb;
  wire         mismatch;

  // The long sequence uses taps 15 and 14, the short one taps 9 and 5.
  assign gen_fb   = long_sel_in ? (gen_reg[14] ^ gen_reg[13]) : (gen_reg[8] ^ gen_reg[4]);
  assign chk_fb   = long_sel_in ? (chk_reg[14] ^ chk_reg[13]) : (chk_reg[8] ^ chk_reg[4]);
  assign mismatch = (fill_reg == 4'hf) & (rx_bit_in ^ chk_fb);

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gen_reg    <= {W{1'b1}};
      chk_reg    <= {W{1'b0}};
      fill_reg   <= 4'h0;
      active_reg <= 1'b0;
      tx_bit_out <= 1'b0;
      pass_out   <= 1'b0;
      fail_out   <= 1'b0;
    end else if (ce_in) begin
      fail_out <= 1'b0;
      if (!run_in) begin
        gen_reg    <= {W{1'b1}};
        fill_reg   <= 4'h0;
        active_reg <= 1'b0;
        tx_bit_out <= 1'b0;
        pass_out   <= 1'b0;
      end else begin
        gen_reg    <= {gen_reg[W-2:0], gen_fb};
        chk_reg    <= {chk_reg[W-2:0], rx_bit_in};
        tx_bit_out <= gen_fb ^ inject_in;
        if (active_reg && fill_reg != 4'hf) begin
          fill_reg <= fill_reg + 4'h1;
        end
        if (!active_reg) begin
          active_reg <= 1'b1;
          pass_out   <= 1'b1;
        end else if (mismatch) begin
          pass_out <= 1'b0;
          fail_out <= pass_out;
        end
      end
    end
  end
endmodule

// file: verilog/plcr_regs.v
// Purpose: Indicator override and transceiver control register bank.
// Assumes: Straps are stable at reset release; inputs synchronous to clk_in.
// Notes:   All state freezes while ce_in is low.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "plcr_defs.vh"
module plcr_regs #(
  parameter STRETCH_CYCLES = `PLCR_STRETCH_CYCLES
) (
  input  wire        clk_in,
  input  wire        reset_n_in,
  input  wire        ce_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output wire [1:0]  s_axi_bresp_out,
  output wire        s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0]  s_axi_rresp_out,
  output wire        s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        strap_auto_crossover_in,
  input  wire        strap_indicator_mode_in,
  input  wire [4:0]  strap_port_address_in,
  input  wire        link_good_in,
  input  wire        activity_in,
  input  wire [1:0]  local_advertise_pause_in,
  input  wire [1:0]  partner_ability_pause_in,
  input  wire        hcd_full_duplex_in,
  input  wire        selftest_rx_bit_in,
  output wire        selftest_tx_bit_out,
  output reg         link_indicator_pin_out,
  output reg         activity_indicator_out,
  output wire        auto_crossover_enable_out,
  output wire        forced_crossover_out,
  output wire        indicator_mode_select_out,
  output wire [4:0]  port_mgmt_address_out,
  output wire        irq_out
);
  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [7:0]  rd_addr;
  reg  [15:0] rd_data;
  reg         rd_hit;
  reg         wr_hit;

  reg         override_en_reg;
  reg         override_val_reg;
  reg         auto_crossover_reg;
  reg         forced_crossover_reg;
  reg         inject_reg;
  reg         long_seq_reg;
  reg         run_reg;
  reg         bypass_reg;
  reg         mode_reg;
  reg  [4:0]  address_reg;
  reg         straps_loaded_reg;
  reg         pause_rx_reg;
  reg         pause_tx_reg;
  reg         link_prev_reg;
  reg  [`PLCR_IRQ_W-1:0] irq_status_reg;
  reg  [`PLCR_IRQ_W-1:0] irq_enable_reg;
  reg  [`PLCR_IRQ_W-1:0] irq_event;
  reg  [`PLCR_IRQ_W-1:0] irq_clear;
  reg  [31:0] stretch_count_reg;
  reg         stretched_act;
  reg         pause_rx_next;
  reg         pause_tx_next;
  reg         normal_link;

  wire        selftest_pass;
  wire        selftest_fail;
  wire        wr_override;
  wire        wr_control;
  wire        wr_clear;
  wire        wr_enable;
  wire [15:0] control_word;
  wire [15:0] override_word;

  plcr_axil_slave u_bus (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .ce_in       (ce_in),
    .awaddr_in   (s_axi_awaddr_in),
    .awvalid_in  (s_axi_awvalid_in),
    .awready_out (s_axi_awready_out),
    .wdata_in    (s_axi_wdata_in),
    .wstrb_in    (s_axi_wstrb_in),
    .wvalid_in   (s_axi_wvalid_in),
    .wready_out  (s_axi_wready_out),
    .bresp_out   (s_axi_bresp_out),
    .bvalid_out  (s_axi_bvalid_out),
    .bready_in   (s_axi_bready_in),
    .araddr_in   (s_axi_araddr_in),
    .arvalid_in  (s_axi_arvalid_in),
    .arready_out (s_axi_arready_out),
    .rdata_out   (s_axi_rdata_out),
    .rresp_out   (s_axi_rresp_out),
    .rvalid_out  (s_axi_rvalid_out),
    .rready_in   (s_axi_rready_in),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb),
    .wr_hit_in   (wr_hit),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_data),
    .rd_hit_in   (rd_hit)
  );

  plcr_selftest #(
    .W (`PLCR_SEQ_LEN)
  ) u_selftest (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .ce_in       (ce_in),
    .run_in      (run_reg),
    .long_sel_in (long_seq_reg),
    .inject_in   (inject_reg),
    .rx_bit_in   (selftest_rx_bit_in),
    .tx_bit_out  (selftest_tx_bit_out),
    .pass_out    (selftest_pass),
    .fail_out    (selftest_fail)
  );

  assign wr_override = wr_en && (wr_addr == {`PLCR_IDX_OVERRIDE, 2'b00});
  assign wr_control  = wr_en && (wr_addr == {`PLCR_IDX_CONTROL, 2'b00});
  assign wr_clear    = wr_en && (wr_addr == {`PLCR_IDX_IRQ_CLEAR, 2'b00});
  assign wr_enable   = wr_en && (wr_addr == {`PLCR_IDX_IRQ_ENABLE, 2'b00});

  always @* begin
    wr_hit = (wr_addr == {`PLCR_IDX_OVERRIDE, 2'b00}) ||
             (wr_addr == {`PLCR_IDX_CONTROL, 2'b00}) ||
             (wr_addr == {`PLCR_IDX_IRQ_STATUS, 2'b00}) ||
             (wr_addr == {`PLCR_IDX_IRQ_CLEAR, 2'b00}) ||
             (wr_addr == {`PLCR_IDX_IRQ_ENABLE, 2'b00});
  end

  // Stored bits only; reserved positions are constant zero.
  assign override_word = {11'h000, override_en_reg, 2'b00, override_val_reg, 1'b0};

  assign control_word = {auto_crossover_reg, forced_crossover_reg, pause_rx_reg, pause_tx_reg,
                         inject_reg, long_seq_reg, selftest_pass, run_reg,
                         bypass_reg, 1'b0, mode_reg, address_reg};

  always @* begin
    rd_hit  = 1'b1;
    rd_data = 16'h0000;
    case (rd_addr)
      {`PLCR_IDX_OVERRIDE, 2'b00}: begin
        rd_data = override_word;
      end
      {`PLCR_IDX_CONTROL, 2'b00}: begin
        rd_data = control_word;
      end
      {`PLCR_IDX_IRQ_STATUS, 2'b00}: begin
        rd_data = {13'h0000, irq_status_reg};
      end
      {`PLCR_IDX_IRQ_CLEAR, 2'b00}: begin
        rd_data = 16'h0000;
      end
      {`PLCR_IDX_IRQ_ENABLE, 2'b00}: begin
        rd_data = {13'h0000, irq_enable_reg};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Indicator override register.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      override_en_reg  <= 1'b0;
      override_val_reg <= 1'b0;
    end else if (ce_in) begin
      if (wr_override && wr_strb[0]) begin
        override_en_reg  <= wr_data[`PLCR_OVR_EN_BIT];
        override_val_reg <= wr_data[`PLCR_OVR_VAL_BIT];
      end
    end
  end

  // Transceiver control register; strap fields load once after reset.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      straps_loaded_reg    <= 1'b0;
      auto_crossover_reg   <= 1'b0;
      forced_crossover_reg <= 1'b0;
      inject_reg           <= 1'b0;
      long_seq_reg         <= 1'b0;
      run_reg              <= 1'b0;
      bypass_reg           <= 1'b0;
      mode_reg             <= 1'b0;
      address_reg          <= 5'h00;
    end else if (ce_in) begin
      inject_reg <= 1'b0;
      if (!straps_loaded_reg) begin
        straps_loaded_reg  <= 1'b1;
        auto_crossover_reg <= strap_auto_crossover_in;
        mode_reg           <= strap_indicator_mode_in;
        address_reg        <= strap_port_address_in;
      end else if (wr_control) begin
        if (wr_strb[1]) begin
          auto_crossover_reg   <= wr_data[`PLCR_CTL_XOVER_AUTO];
          forced_crossover_reg <= wr_data[`PLCR_CTL_XOVER_FORCE];
          inject_reg           <= wr_data[`PLCR_CTL_INJECT];
          long_seq_reg         <= wr_data[`PLCR_CTL_LONG_SEQ];
          run_reg              <= wr_data[`PLCR_CTL_RUN];
        end
        if (wr_strb[0]) begin
          bypass_reg  <= wr_data[`PLCR_CTL_BYPASS];
          mode_reg    <= wr_data[`PLCR_CTL_MODE];
          address_reg <= wr_data[4:0];
        end
      end
    end
  end

  assign auto_crossover_enable_out = auto_crossover_reg;
  assign forced_crossover_out      = forced_crossover_reg;
  assign indicator_mode_select_out = mode_reg;
  assign port_mgmt_address_out     = address_reg;

  // Symmetric and asymmetric pause resolution, full duplex only.
  always @* begin
    pause_rx_next = hcd_full_duplex_in &
                    ((local_advertise_pause_in[0] & partner_ability_pause_in[0]) |
                     (local_advertise_pause_in[0] & local_advertise_pause_in[1] &
                      ~partner_ability_pause_in[0] & partner_ability_pause_in[1]));
    pause_tx_next = hcd_full_duplex_in &
                    ((local_advertise_pause_in[0] & partner_ability_pause_in[0]) |
                     (~local_advertise_pause_in[0] & local_advertise_pause_in[1] &
                      partner_ability_pause_in[0] & partner_ability_pause_in[1]));
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pause_rx_reg <= 1'b0;
      pause_tx_reg <= 1'b0;
    end else if (ce_in) begin
      pause_rx_reg <= pause_rx_next;
      pause_tx_reg <= pause_tx_next;
    end
  end

  // Activity pulses are held on for the stretch time unless bypassed.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stretch_count_reg <= 32'h0000_0000;
    end else if (ce_in) begin
      if (activity_in) begin
        stretch_count_reg <= STRETCH_CYCLES;
      end else if (stretch_count_reg != 32'h0000_0000) begin
        stretch_count_reg <= stretch_count_reg - 32'h0000_0001;
      end
    end
  end

  always @* begin
    stretched_act = bypass_reg ? activity_in
                               : (activity_in | (stretch_count_reg != 32'h0000_0000));
    normal_link = mode_reg ? link_good_in
                           : (link_good_in & ~stretched_act);
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_indicator_pin_out <= 1'b0;
      activity_indicator_out <= 1'b0;
    end else if (ce_in) begin
      link_indicator_pin_out <= override_en_reg ? override_val_reg : normal_link;
      activity_indicator_out <= stretched_act & mode_reg;
    end
  end

  // Sticky interrupt status; a new event wins over a clear in one cycle.
  always @* begin
    irq_event = {`PLCR_IRQ_W{1'b0}};
    irq_event[`PLCR_IRQ_FAIL]  = selftest_fail;
    irq_event[`PLCR_IRQ_PAUSE] = (pause_rx_next != pause_rx_reg) |
                                 (pause_tx_next != pause_tx_reg);
    irq_event[`PLCR_IRQ_LINK]  = link_good_in ^ link_prev_reg;
    irq_clear = (wr_clear && wr_strb[0]) ? wr_data[`PLCR_IRQ_W-1:0] : {`PLCR_IRQ_W{1'b0}};
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status_reg <= {`PLCR_IRQ_W{1'b0}};
      irq_enable_reg <= {`PLCR_IRQ_W{1'b0}};
      link_prev_reg  <= 1'b0;
    end else if (ce_in) begin
      link_prev_reg  <= link_good_in;
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
      if (wr_enable && wr_strb[0]) begin
        irq_enable_reg <= wr_data[`PLCR_IRQ_W-1:0];
      end
    end
  end

  assign irq_out = |(irq_status_reg & irq_enable_reg);
endmodule

// file: test/plcr_regs_sva.sv
// Purpose: Port-level checks for the indicator override and control register bank.
// Assumes: Single clock domain; a bus write has landed when bvalid rises.
// Notes:   Override copies lag the design by one edge, like the pin.
`timescale 1ns/1ps
module plcr_regs_sva (
  input wire        clk_in,
  input wire        reset_n_in,
  input wire [7:0]  s_axi_awaddr_in,
  input wire        s_axi_awvalid_in,
  input wire        s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0]  s_axi_wstrb_in,
  input wire        s_axi_wvalid_in,
  input wire        s_axi_wready_out,
  input wire [1:0]  s_axi_bresp_out,
  input wire        s_axi_bvalid_out,
  input wire [7:0]  s_axi_araddr_in,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0]  s_axi_rresp_out,
  input wire        s_axi_rvalid_out,
  input wire        strap_auto_crossover_in,
  input wire        strap_indicator_mode_in,
  input wire [4:0]  strap_port_address_in,
  input wire        link_good_in,
  input wire        link_indicator_pin_out,
  input wire        auto_crossover_enable_out,
  input wire        forced_crossover_out,
  input wire        indicator_mode_select_out,
  input wire [4:0]  port_mgmt_address_out
);
  reg  [7:0]  wa_reg;
  reg  [7:0]  ra_reg;
  reg  [15:0] wd_reg;
  reg  [1:0]  ws_reg;
  reg         bv_reg;
  reg         ovr_en_reg;
  reg         ovr_val_reg;
  wire        wr_ok;
  assign wr_ok = s_axi_bvalid_out && !bv_reg && s_axi_bresp_out == 2'b00 && ws_reg == 2'b11;
  // Tracks accepted bus transfers and the override bits that they store.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wa_reg <= 8'h00;
      ra_reg <= 8'h00;
      wd_reg <= 16'h0000;
      ws_reg <= 2'b00;
      bv_reg <= 1'b0;
      ovr_en_reg <= 1'b0;
      ovr_val_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) wa_reg <= s_axi_awaddr_in;
      if (s_axi_arvalid_in && s_axi_arready_out) ra_reg <= s_axi_araddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out) wd_reg <= s_axi_wdata_in[15:0];
      if (s_axi_wvalid_in && s_axi_wready_out) ws_reg <= s_axi_wstrb_in[1:0];
      bv_reg <= s_axi_bvalid_out;
      if (wr_ok && wa_reg == 8'h60) {ovr_en_reg, ovr_val_reg} <= {wd_reg[4], wd_reg[1]};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_strap_load: assert property (
    $rose(reset_n_in) |=> port_mgmt_address_out == $past(strap_port_address_in) &&
    auto_crossover_enable_out == $past(strap_auto_crossover_in) &&
    indicator_mode_select_out == $past(strap_indicator_mode_in)) else $error("strap load");
  chk_xover_write: assert property (
    wr_ok && wa_reg == 8'h64 |-> auto_crossover_enable_out == wd_reg[15] &&
    forced_crossover_out == wd_reg[14]) else $error("crossover bits");
  chk_mode_addr: assert property (
    wr_ok && wa_reg == 8'h64 |-> indicator_mode_select_out == wd_reg[5] &&
    port_mgmt_address_out == wd_reg[4:0]) else $error("mode or address");
  chk_ovr_force: assert property (
    ovr_en_reg |-> link_indicator_pin_out == ovr_val_reg) else $error("forced pin");
  chk_link_follow: assert property (
    indicator_mode_select_out ##1 !ovr_en_reg |-> link_indicator_pin_out == $past(link_good_in))
    else $error("pin not following link");
  chk_ovr_read: assert property (
    s_axi_rvalid_out && ra_reg == 8'h60 |->
    s_axi_rdata_out == {27'h0, ovr_en_reg, 2'b00, ovr_val_reg, 1'b0}) else $error("override read");
  chk_ctl_resv: assert property (
    s_axi_rvalid_out && ra_reg == 8'h64 |-> s_axi_rdata_out[31:16] == 16'h0 &&
    !s_axi_rdata_out[6]) else $error("control reserved bits");
  chk_read_lat: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read latency");
  chk_unmapped_rd: assert property (
    s_axi_rvalid_out && ra_reg > 8'h78 |-> s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 0)
    else $error("unmapped read");
  cover property (wr_ok && wa_reg == 8'h60);
  cover property (ovr_en_reg && !link_indicator_pin_out);
  cover property (s_axi_rvalid_out && ra_reg == 8'h80);
endmodule
bind plcr_regs plcr_regs_sva u_sva (.*);

// file: test/testbench.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Bus answers are compared in order by a monitor process.
// Notes:   Self-test stream is looped back; clock enable stays high.
`timescale 1ns/1ps
`include "plcr_defs.vh"
module testbench;
  localparam [1:0] RSP_OK = `PLCR_RESP_OKAY;
  localparam [1:0] RSP_ERR = `PLCR_RESP_SLVERR;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, ce_in = 1'b1, activity_in = 1'b0;
  logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0]  s_axi_wstrb_in = 4'hf;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic        strap_auto_crossover_in = 1'b0, strap_indicator_mode_in = 1'b0;
  logic [4:0]  strap_port_address_in = 5'h00;
  logic        link_good_in = 1'b0, hcd_full_duplex_in = 1'b0;
  logic [1:0]  local_advertise_pause_in = 2'h0, partner_ability_pause_in = 2'h0;
  wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire         s_axi_arready_out, s_axi_rvalid_out, irq_out, activity_indicator_out;
  wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0]  s_axi_rdata_out;
  wire         selftest_tx_bit_out, link_indicator_pin_out, indicator_mode_select_out;
  wire         auto_crossover_enable_out, forced_crossover_out;
  wire [4:0]   port_mgmt_address_out;
  wire         selftest_rx_bit_in = selftest_tx_bit_out;
  logic [67:0] exp_q[$];
  logic [67:0] e;
  logic [15:0] d;
  int          err_count = 0, total_checks = 0, cycles = 0, k;
  plcr_regs #(.STRETCH_CYCLES(8)) DUT (.*);
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic check(input [33:0] seen, input [33:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [15:0] v, input [1:0] r);
    exp_q.push_back({2'b11, 32'h0, r, 32'h0});
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {16'h0, v};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [15:0] m, input [15:0] v, input [1:0] r);
    exp_q.push_back({2'b11, 16'hffff, m, r, 16'h0, v & m});
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
  endtask
  function automatic [15:0] pause_exp(input fd, input [1:0] l, input [1:0] p);
    pause_exp = {2'b00, fd & (l[0] & p[0] | l[0] & l[1] & !p[0] & p[1]),
                 fd & (l[0] & p[0] | !l[0] & l[1] & p[0] & p[1]), 12'h000};
  endfunction
  // Monitor: every bus answer is matched against the oldest expectation.
  always @(posedge clk_in) begin
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      e = exp_q.pop_front();
      check({s_axi_bresp_out, 32'h0} & e[67:34], e[33:0]);
    end
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      e = exp_q.pop_front();
      check({s_axi_rresp_out, s_axi_rdata_out} & e[67:34], e[33:0]);
    end
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(94853));
    d = $urandom;
    strap_auto_crossover_in <= d[15];
    strap_indicator_mode_in <= d[5];
    strap_port_address_in <= d[4:0];
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(8'h64, 16'hffff, {d[15], 9'h0, d[5], d[4:0]}, RSP_OK);
    rd(8'h60, 16'hffff, 16'h0000, RSP_OK);
    wr(8'h60, 16'hffff, RSP_OK);
    rd(8'h60, 16'hffff, 16'h0012, RSP_OK);
    check(link_indicator_pin_out, 1'b1);
    link_good_in <= 1'b1;
    wr(8'h60, 16'h0010, RSP_OK);
    rd(8'h60, 16'hffff, 16'h0010, RSP_OK);
    check(link_indicator_pin_out, 1'b0);
    wr(8'h60, 16'h0000, RSP_OK);
    for (k = 0; k < 8; k++) begin
      d = $urandom;
      d[8] = 1'b0;
      link_good_in <= d[9];
      wr(8'h64, d, RSP_OK);
      rd(8'h64, 16'hffff, d & 16'hc4bf, RSP_OK);
      check(link_indicator_pin_out, link_good_in);
    end
    s_axi_wstrb_in <= 4'h1;
    wr(8'h64, 16'hffff, RSP_OK);
    rd(8'h64, 16'hffff, {d[15:8], 8'hff} & 16'hc4bf, RSP_OK);
    s_axi_wstrb_in <= 4'hf;
    for (k = 0; k < 32; k++) begin
      {hcd_full_duplex_in, local_advertise_pause_in, partner_ability_pause_in} <= k[4:0];
      activity_in <= k[0];
      rd(8'h64, 16'h3000, pause_exp(k[4], k[3:2], k[1:0]), RSP_OK);
      check(activity_indicator_out, k[0]);
    end
    wr(8'h78, 16'h0000, RSP_OK);
    wr(8'h74, 16'h0007, RSP_OK);
    for (k = 0; k < 2; k++) begin
      wr(8'h64, {5'h0, k[0], 2'b01, 8'h00}, RSP_OK);
      repeat (60) @(posedge clk_in);
      rd(8'h64, 16'h0f00, {5'h0, k[0], 2'b11, 8'h00}, RSP_OK);
      wr(8'h64, {4'h0, 1'b1, k[0], 2'b01, 8'h00}, RSP_OK);
      repeat (60) @(posedge clk_in);
      rd(8'h64, 16'h0f00, {5'h0, k[0], 2'b01, 8'h00}, RSP_OK);
      wr(8'h64, 16'h0000, RSP_OK);
      rd(8'h64, 16'h0f00, 16'h0000, RSP_OK);
    end
    check(irq_out, 1'b0);
    rd(8'h70, 16'h0001, 16'h0001, RSP_OK);
    wr(8'h78, 16'h0001, RSP_OK);
    check(irq_out, 1'b1);
    wr(8'h74, 16'h0001, RSP_OK);
    check(irq_out, 1'b0);
    rd(8'h74, 16'hffff, 16'h0000, RSP_OK);
    wr(8'h84, 16'hffff, RSP_ERR);
    rd(8'h80, 16'hffff, 16'h0000, RSP_ERR);
    repeat (2) @(posedge clk_in);
    wrap_up();
  end
endmodule
